/* hw/mise_exec.v */
// execution unit for swap, skip, table-read and xor instructions
`timescale 1ns/1ps
module mise_exec #(
  parameter PADDR_W = 16
) (
  // clock and reset
  input wire clk_in,
  input wire rstn_in,
  // instruction issue from fetch logic
  input wire start_in,
  input wire [3:0] op_in,
  input wire [7:0] mem_addr_in,
  input wire [2:0] bit_sel_in,
  input wire [7:0] imm_in,
  output wire ready_out,
  // data memory port
  input wire [7:0] mem_rdata_in,
  output reg [7:0] mem_addr_out,
  output reg [7:0] mem_wdata_out,
  output reg mem_we_out,
  // program memory port, data valid one cycle after request
  output reg [PADDR_W-1:0] pmem_addr_out,
  output reg pmem_re_out,
  input wire [15:0] pmem_rdata_in,
  // table pointers from the register file
  input wire [7:0] table_pointer_low_in,
  input wire [7:0] table_pointer_high_in,
  input wire has_table_pointer_high_in,
  // architectural state and status
  output reg [7:0] working_register_out,
  output reg [7:0] table_high_latch_out,
  output reg zero_flag_out,
  output reg zero_flag_we_out,
  output reg skip_out,
  output reg done_out
);
`include "mise_consts.vh"
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // program word address: high pointer byte above low pointer byte
  function [PADDR_W-1:0] mise_tab_addr;
    input [7:0] hi;
    input [7:0] lo;
    begin
      mise_tab_addr = {{(PADDR_W-`MISE_BYTE_W){1'b0}}, lo}
                      | ({{(PADDR_W-`MISE_BYTE_W){1'b0}}, hi} << `MISE_BYTE_W);
    end
  endfunction

  // ----------------------------------------
  // state and decode nets
  // ----------------------------------------
  reg [1:0] state;
  reg [1:0] next_state;
  wire [7:0] alu_res;
  wire alu_zero;
  wire is_imm;
  wire is_swap;
  wire mem_zero;
  wire bit_clr;

  // ----------------------------------------
  // operand decode
  // ----------------------------------------
  // tests use the raw read data, so the skip decision and the dummy
  // cycle are both settled in the issue cycle itself
  assign is_imm = (op_in == `MISE_OP_XOR_IMM);
  assign is_swap = (op_in == `MISE_OP_SWAP_TO_REG);
  assign mem_zero = (mem_rdata_in == `MISE_ZERO_BYTE);
  assign bit_clr = ~mem_rdata_in[bit_sel_in];
  // new instruction only accepted while idle in execute state
  // a start seen while busy is dropped, not queued: fetch must hold it
  assign ready_out = (state == `MISE_ST_EXEC);

  // ----------------------------------------
  // result unit
  // ----------------------------------------
  // swap and xor share one unit; only the xor forms use its zero flag
  mise_alu u_alu (
    .mem_in(mem_rdata_in),
    .wreg_in(working_register_out),
    .imm_in(imm_in),
    .use_imm_in(is_imm),
    .swap_in(is_swap),
    .res_out(alu_res),
    .zero_out(alu_zero)
  );

  // ----------------------------------------
  // execute sequencing
  // ----------------------------------------
  // memory read data is taken combinationally in the issue cycle, so the
  // fetch logic must present mem_addr_in to memory with zero-wait reads
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      state <= `MISE_ST_EXEC;
      working_register_out <= `MISE_WREG_RST;
      table_high_latch_out <= `MISE_LATCH_RST;
      zero_flag_out <= 1'b0;
      zero_flag_we_out <= 1'b0;
      mem_addr_out <= `MISE_ZERO_BYTE;
      mem_wdata_out <= `MISE_ZERO_BYTE;
      mem_we_out <= 1'b0;
      pmem_addr_out <= {PADDR_W{1'b0}};
      pmem_re_out <= 1'b0;
      skip_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      state <= next_state;
      // strobes default low; only the decoded branch below raises one
      mem_we_out <= 1'b0;
      pmem_re_out <= 1'b0;
      zero_flag_we_out <= 1'b0;
      skip_out <= 1'b0;
      done_out <= 1'b0;
      case (state)
        `MISE_ST_EXEC: begin
          if (start_in) begin
            mem_addr_out <= mem_addr_in;
            case (op_in)
              `MISE_OP_SWAP_TO_REG: begin
                working_register_out <= alu_res;
                done_out <= 1'b1;
              end
              `MISE_OP_SKIP_ZERO: begin
                // byte goes back unchanged; the write keeps its bus cycle
                mem_wdata_out <= mem_rdata_in;
                mem_we_out <= 1'b1;
                skip_out <= mem_zero;
                done_out <= ~mem_zero;
              end
              `MISE_OP_SKIP_ZERO_MOVE: begin
                working_register_out <= mem_rdata_in;
                skip_out <= mem_zero;
                done_out <= ~mem_zero;
              end
              `MISE_OP_SKIP_BIT_CLR: begin
                skip_out <= bit_clr;
                done_out <= ~bit_clr;
              end
              `MISE_OP_TAB_CUR: begin
                pmem_re_out <= 1'b1;
                if (has_table_pointer_high_in) begin
                  pmem_addr_out <= mise_tab_addr(table_pointer_high_in,
                                                 table_pointer_low_in);
                end else begin
                  // parts without a high pointer read from page zero
                  pmem_addr_out <= mise_tab_addr(`MISE_ZERO_BYTE, table_pointer_low_in);
                end
              end
              `MISE_OP_TAB_LAST: begin
                pmem_re_out <= 1'b1;
                // high pointer ignored: the last page is fixed
                pmem_addr_out <= mise_tab_addr(`MISE_LAST_PAGE, table_pointer_low_in);
              end
              `MISE_OP_XOR_REG, `MISE_OP_XOR_IMM: begin
                working_register_out <= alu_res;
                zero_flag_out <= alu_zero;
                zero_flag_we_out <= 1'b1;
                done_out <= 1'b1;
              end
              `MISE_OP_XOR_MEM: begin
                // zero flag follows the stored result, not the working register
                mem_wdata_out <= alu_res;
                mem_we_out <= 1'b1;
                zero_flag_out <= alu_zero;
                zero_flag_we_out <= 1'b1;
                done_out <= 1'b1;
              end
              default: begin
                done_out <= 1'b1;
              end
            endcase
          end
        end
        `MISE_ST_TAB: begin
          // program word is valid one cycle after the request
          mem_wdata_out <= pmem_rdata_in[`MISE_LO_BYTE];
          mem_we_out <= 1'b1;
          table_high_latch_out <= pmem_rdata_in[`MISE_HI_BYTE];
          done_out <= 1'b1;
        end
        `MISE_ST_DUMMY: begin
          // stands in for the skipped instruction while fetch moves on
          done_out <= 1'b1;
        end
        default: begin
          done_out <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // next-state
  // ----------------------------------------
  // skip decode here must match skip_out above, or fetch loses a slot
  always @* begin
    next_state = state;
    case (state)
      `MISE_ST_EXEC: begin
        if (start_in) begin
          case (op_in)
            `MISE_OP_TAB_CUR, `MISE_OP_TAB_LAST: next_state = `MISE_ST_TAB;
            `MISE_OP_SKIP_ZERO, `MISE_OP_SKIP_ZERO_MOVE: begin
              if (mem_zero) begin
                next_state = `MISE_ST_DUMMY;
              end
            end
            `MISE_OP_SKIP_BIT_CLR: begin
              if (bit_clr) begin
                next_state = `MISE_ST_DUMMY;
              end
            end
            default: next_state = `MISE_ST_EXEC;
          endcase
        end
      end
      `MISE_ST_TAB: next_state = `MISE_ST_EXEC;
      `MISE_ST_DUMMY: next_state = `MISE_ST_EXEC;
      default: next_state = `MISE_ST_EXEC;
    endcase
  end
endmodule

/* hw/mise_consts.vh */
// constants for the instruction-subset execution unit
`ifndef MISE_CONSTS_VH
`define MISE_CONSTS_VH
// ----------------------------------------
// operation codes on op_in
// ----------------------------------------
`define MISE_OP_NOP 4'h0
`define MISE_OP_SWAP_TO_REG 4'h1
`define MISE_OP_SKIP_ZERO 4'h2
`define MISE_OP_SKIP_ZERO_MOVE 4'h3
`define MISE_OP_SKIP_BIT_CLR 4'h4
`define MISE_OP_TAB_CUR 4'h5
`define MISE_OP_TAB_LAST 4'h6
`define MISE_OP_XOR_REG 4'h7
`define MISE_OP_XOR_MEM 4'h8
`define MISE_OP_XOR_IMM 4'h9
// ----------------------------------------
// reset values and fields
// ----------------------------------------
`define MISE_WREG_RST 8'h00
`define MISE_LATCH_RST 8'h00
`define MISE_ZERO_BYTE 8'h00
`define MISE_LO_BYTE 7:0
`define MISE_HI_BYTE 15:8
`define MISE_LO_NIB 3:0
`define MISE_HI_NIB 7:4
`define MISE_BYTE_W 8
`define MISE_LAST_PAGE 8'hFF
// ----------------------------------------
// states
// ----------------------------------------
`define MISE_ST_EXEC 2'h0
`define MISE_ST_TAB 2'h1
`define MISE_ST_DUMMY 2'h2
`endif

/* hw/mise_alu.v */
// combinational result for the xor and swap forms, zero flag for the xor forms only
`timescale 1ns/1ps
module mise_alu (
  // operands
  input wire [7:0] mem_in,
  input wire [7:0] wreg_in,
  input wire [7:0] imm_in,
  input wire use_imm_in,
  input wire swap_in,
  // result
  output wire [7:0] res_out,
  output wire zero_out
);
`include "mise_consts.vh"
  wire [7:0] xr;
  assign xr = wreg_in ^ (use_imm_in ? imm_in : mem_in);
  assign res_out = swap_in ? {mem_in[`MISE_LO_NIB], mem_in[`MISE_HI_NIB]} : xr;
  assign zero_out = (xr == `MISE_ZERO_BYTE);
endmodule

/* dv/mise_exec_sva.sv */
// assertion checker for the instruction-subset execution unit
`timescale 1ns/1ps
`include "mise_consts.vh"
module mise_exec_sva (
  // observed ports
  input wire clk_in,
  input wire rstn_in,
  input wire start_in,
  input wire [3:0] op_in,
  input wire [2:0] bit_sel_in,
  input wire [7:0] mem_rdata_in,
  input wire [7:0] imm_in,
  input wire ready_out,
  input wire [7:0] mem_wdata_out,
  input wire mem_we_out,
  input wire pmem_re_out,
  input wire [7:0] working_register_out,
  input wire zero_flag_out,
  input wire zero_flag_we_out,
  input wire skip_out,
  input wire done_out
);
  logic [7:0] rd_q;
  logic [7:0] wr_q;
  logic [2:0] bs_q;
  logic [7:0] im_q;
  wire go = start_in && ready_out;
  // operands as seen at the issue edge, for comparison one cycle later
  always @(posedge clk_in) begin
    rd_q <= mem_rdata_in;
    wr_q <= working_register_out;
    bs_q <= bit_sel_in;
    im_q <= imm_in;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // ----------------------------------------
  // sequences and assertions
  // ----------------------------------------
  sequence s_taken;
    ##1 (skip_out && !ready_out && !done_out) ##1 (done_out && ready_out);
  endsequence
  sequence s_table;
    ##1 (pmem_re_out && !ready_out) ##1 (mem_we_out && done_out && !zero_flag_we_out);
  endsequence
  a_swap_nibbles: assert property (
    go && op_in == `MISE_OP_SWAP_TO_REG |=> working_register_out == {rd_q[3:0], rd_q[7:4]}
    && !zero_flag_we_out && !mem_we_out) else $error("swap result wrong");
  a_skip_writeback: assert property (
    go && op_in == `MISE_OP_SKIP_ZERO |=> mem_we_out && mem_wdata_out == rd_q
    && !zero_flag_we_out) else $error("skip write-back wrong");
  a_skip_taken: assert property (
    go && op_in inside {`MISE_OP_SKIP_ZERO, `MISE_OP_SKIP_ZERO_MOVE} && mem_rdata_in == 8'h00
    |-> s_taken) else $error("taken skip timing wrong");
  a_skip_not_taken: assert property (
    go && op_in == `MISE_OP_SKIP_ZERO && mem_rdata_in != 8'h00 |=> done_out && !skip_out
    && ready_out) else $error("untaken skip wrong");
  a_move_value: assert property (
    go && op_in == `MISE_OP_SKIP_ZERO_MOVE |=> working_register_out == rd_q
    && !zero_flag_we_out) else $error("move value wrong");
  a_bit_test: assert property (
    go && op_in == `MISE_OP_SKIP_BIT_CLR |=> skip_out == !rd_q[bs_q] && !mem_we_out)
    else $error("bit test wrong");
  a_table_steps: assert property (
    go && op_in inside {`MISE_OP_TAB_CUR, `MISE_OP_TAB_LAST} |-> s_table)
    else $error("table read steps wrong");
  a_xor_memory: assert property (
    go && op_in == `MISE_OP_XOR_MEM |=> mem_we_out && mem_wdata_out == (rd_q ^ wr_q)
    && zero_flag_we_out && zero_flag_out == (mem_wdata_out == 8'h00)) else $error("xor wrong");
  a_xor_register: assert property (
    go && op_in == `MISE_OP_XOR_REG |=> working_register_out == (rd_q ^ wr_q) && !mem_we_out
    && zero_flag_we_out && zero_flag_out == (working_register_out == 8'h00))
    else $error("xor to register wrong");
  a_xor_immediate: assert property (
    go && op_in == `MISE_OP_XOR_IMM |=> working_register_out == (im_q ^ wr_q) && !mem_we_out
    && zero_flag_we_out && zero_flag_out == (working_register_out == 8'h00))
    else $error("xor immediate wrong");
endmodule
bind mise_exec mise_exec_sva chk_u (
  .clk_in(clk_in),
  .rstn_in(rstn_in),
  .start_in(start_in),
  .op_in(op_in),
  .bit_sel_in(bit_sel_in),
  .mem_rdata_in(mem_rdata_in),
  .imm_in(imm_in),
  .ready_out(ready_out),
  .mem_wdata_out(mem_wdata_out),
  .mem_we_out(mem_we_out),
  .pmem_re_out(pmem_re_out),
  .working_register_out(working_register_out),
  .zero_flag_out(zero_flag_out),
  .zero_flag_we_out(zero_flag_we_out),
  .skip_out(skip_out),
  .done_out(done_out)
);

/* dv/tb_top.sv */
// self-checking bench for the instruction-subset execution unit
`timescale 1ns/1ps
`include "mise_consts.vh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("ERROR %0t got %h exp %h", $time, a, b); end end
module tb_top;
  logic clk_in = 0;
  logic rstn_in = 0;
  logic start_in = 0;
  logic [3:0] op_in = 0;
  logic [7:0] mem_rdata_in = 0;
  logic [2:0] bit_sel_in = 0;
  logic [7:0] imm_in = 0;
  logic [7:0] mem_addr_in = 8'h21;
  logic [15:0] pmem_rdata_in = 0;
  logic [7:0] tpl = 8'h12;
  logic [7:0] tph = 8'h34;
  logic has_tph = 0;
  int n_errors = 0;
  int total_checks = 0;
  wire ready_out, mem_we_out, pmem_re_out, zero_flag_out, zero_flag_we_out, skip_out, done_out;
  wire [7:0] mem_addr_out, mem_wdata_out, working_register_out, table_high_latch_out;
  wire [15:0] pmem_addr_out;
  mise_exec dut_u (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .start_in(start_in),
    .op_in(op_in),
    .mem_addr_in(mem_addr_in),
    .bit_sel_in(bit_sel_in),
    .imm_in(imm_in),
    .ready_out(ready_out),
    .mem_rdata_in(mem_rdata_in),
    .mem_addr_out(mem_addr_out),
    .mem_wdata_out(mem_wdata_out),
    .mem_we_out(mem_we_out),
    .pmem_addr_out(pmem_addr_out),
    .pmem_re_out(pmem_re_out),
    .pmem_rdata_in(pmem_rdata_in),
    .table_pointer_low_in(tpl),
    .table_pointer_high_in(tph),
    .has_table_pointer_high_in(has_tph),
    .working_register_out(working_register_out),
    .table_high_latch_out(table_high_latch_out),
    .zero_flag_out(zero_flag_out),
    .zero_flag_we_out(zero_flag_we_out),
    .skip_out(skip_out),
    .done_out(done_out)
  );
  initial forever #2.5 clk_in = ~clk_in;
  task end_of_test;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // leaves the bench one step after the edge that took the request
  task iss(input logic [3:0] op, input logic [7:0] rd);
    @(posedge clk_in);
    #1;
    op_in = op;
    mem_rdata_in = rd;
    start_in = 1;
    @(posedge clk_in);
    #1;
    start_in = 0;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_swap;
    iss(`MISE_OP_SWAP_TO_REG, 8'h3C);
    `CHK({working_register_out, done_out, zero_flag_we_out, mem_we_out}, 11'h61C)
  endtask
  task t_skip;
    iss(`MISE_OP_SKIP_ZERO, 8'h00);
    `CHK({skip_out, ready_out, mem_we_out, mem_wdata_out}, {3'b101, 8'h00})
    @(posedge clk_in);
    #1;
    `CHK({done_out, ready_out}, 2'b11)
    iss(`MISE_OP_SKIP_ZERO, 8'h05);
    `CHK({skip_out, done_out, mem_wdata_out}, {2'b01, 8'h05})
    iss(`MISE_OP_SKIP_ZERO_MOVE, 8'h00);
    `CHK({skip_out, working_register_out, zero_flag_we_out}, 10'h200)
    iss(`MISE_OP_SKIP_ZERO_MOVE, 8'h80);
    `CHK({skip_out, working_register_out}, 9'h080)
    for (int i = 0; i < 8; i++) begin
      bit_sel_in = i[2:0];
      iss(`MISE_OP_SKIP_BIT_CLR, ~(8'h01 << i));
      `CHK({skip_out, mem_we_out, zero_flag_we_out}, 3'b100)
      iss(`MISE_OP_SKIP_BIT_CLR, 8'h01 << i);
      `CHK({skip_out, done_out}, 2'b01)
    end
  endtask
  task t_tab(input logic [3:0] op, input logic h, input logic [15:0] exp_a);
    has_tph = h;
    mem_addr_in = 8'h40;
    iss(op, 8'h00);
    `CHK({pmem_re_out, pmem_addr_out}, {1'b1, exp_a})
    pmem_rdata_in = exp_a ^ 16'h5AA5;
    @(posedge clk_in);
    #1;
    pmem_rdata_in = ~pmem_rdata_in;
    `CHK({mem_we_out, table_high_latch_out, mem_wdata_out}, {1'b1, exp_a ^ 16'h5AA5})
    `CHK(mem_addr_out, 8'h40)
  endtask
  task t_xor;
    imm_in = 8'h80;
    mem_addr_in = 8'h21;
    iss(`MISE_OP_XOR_IMM, 8'hFF);
    `CHK({working_register_out, zero_flag_out, zero_flag_we_out}, 10'h003)
    iss(`MISE_OP_XOR_REG, 8'h5A);
    `CHK({working_register_out, zero_flag_out, zero_flag_we_out, mem_we_out}, 11'h2D2)
    iss(`MISE_OP_XOR_MEM, 8'h5A);
    `CHK({mem_wdata_out, mem_addr_out, zero_flag_out, working_register_out}, 25'h0043_5A)
  endtask
  initial begin
    repeat (3) @(posedge clk_in);
    #1;
    rstn_in = 1;
    `CHK({working_register_out, ready_out}, 9'h001)
    t_swap;
    t_skip;
    t_tab(`MISE_OP_TAB_CUR, 1'b1, 16'h3412);
    t_tab(`MISE_OP_TAB_CUR, 1'b0, 16'h0012);
    t_tab(`MISE_OP_TAB_LAST, 1'b1, 16'hFF12);
    t_xor;
    end_of_test;
  end
  initial begin
    repeat (500) @(posedge clk_in);
    n_errors++;
    end_of_test;
  end
endmodule
